// file: src/ufb_pkg.sv
// Purpose: constants for the serial port frame and baud block
// Assumes: 8-bit register port, 3-bit word address
// Notes:   addresses, field positions and reset values

package ufb_pkg;

    // ------------------------------------------------
    // Register addresses
    // ------------------------------------------------
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_STAT_A = 3'h1;
    localparam logic [2:0] ADDR_CTRL_B = 3'h2;
    localparam logic [2:0] ADDR_SHARED = 3'h3;
    localparam logic [2:0] ADDR_DIV_LOW = 3'h4;
    localparam logic [2:0] ADDR_INT_STAT = 3'h5;
    localparam logic [2:0] ADDR_INT_MASK = 3'h6;

    // ------------------------------------------------
    // Field positions
    // ------------------------------------------------
    localparam int SEL_BIT = 7;
    localparam int FRM_MODE = 6;
    localparam int FRM_PAR_EN = 5;
    localparam int FRM_PAR_ODD = 4;
    localparam int FRM_STOP2 = 3;
    localparam int FRM_POL = 0;
    localparam int STA_RX_FULL = 7;
    localparam int STA_TX_EMPTY = 5;
    localparam int STA_FE = 4;
    localparam int STA_PE = 2;
    localparam int STA_DBL = 1;
    localparam int CTL_RXEN = 4;
    localparam int CTL_TXEN = 3;
    localparam int CTL_CSZ2 = 2;
    localparam int CTL_RXB8 = 1;
    localparam int CTL_TXB8 = 0;
    localparam int EV_RXC = 0;
    localparam int EV_TXC = 1;
    localparam int EV_PE = 2;
    localparam int EV_FE = 3;

    // ------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------
    localparam logic [6:0] FRAME_RST = 7'h06;
    localparam int OVS_NORMAL = 16;
    localparam int OVS_DOUBLE = 8;
    localparam logic [3:0] OVS_NORMAL_M1 = 4'(OVS_NORMAL - 1);
    localparam logic [3:0] OVS_DOUBLE_M1 = 4'(OVS_DOUBLE - 1);

    // Receiver states
    typedef enum logic [0:0] {
        RX_IDLE = 1'b0,
        RX_BUSY = 1'b1
    } ufb_rx_e;

    // Character size code to data bit count
    function automatic logic [3:0] ufb_char_len(input logic [2:0] code);
        unique case (code)
            3'h0: ufb_char_len = 4'h5;
            3'h1: ufb_char_len = 4'h6;
            3'h2: ufb_char_len = 4'h7;
            3'h7: ufb_char_len = 4'h9;
            default: ufb_char_len = 4'h8; // Reserved codes act as 8
        endcase
    endfunction : ufb_char_len

endpackage : ufb_pkg

// file: src/ufb_usart.sv
// Purpose: serial port with frame format and baud divisor setup
// Assumes: one 250 MHz clock, inputs synchronous to it
// Notes:   sync mode makes the serial clock (master only)
//
// What this block does
// - Shared location writes the frame register when bit 7 is one.
// - Reading the frame register returns one in bit 7.
// - Bit 7 zero writes divisor high; divisor high reads bit 7 zero.
// - Mode bit 0 asynchronous, 1 synchronous.
// - Parity field: 00 off, 01 reserved, 10 even, 11 odd.
// - Transmitter appends computed parity bit to each frame.
// - Receiver checks parity and sets parity error flag on mismatch.
// - Stop select gives one or two transmitted stops; receiver ignores it.
// - Three-bit character size code: 5,6,7,8 or 9 bits.
// - Sync polarity picks clock edges for data change and sample.
// - Twelve-bit divisor split across high nibble and low byte.
// - Writing divisor low reloads the prescaler at once.
// - Double speed bit makes asynchronous bit eight ticks not sixteen.
// - Unused upper data bits ignored on send, zero on receive.

`timescale 1ns/1ns
`default_nettype none

module ufb_usart
    import ufb_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Serial lines
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_serial_clock_line,
    output logic o_serial_clock_line_oe,
    // Interrupt
    output logic o_irq
);

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef struct packed {
        logic [6:0] frame;
        logic [11:0] div;
        logic [11:0] pre;
        logic rxen;
        logic txen;
        logic csz2;
        logic txb8;
        logic dbl;
        logic [8:0] thr;
        logic thr_full;
        logic tx_busy;
        logic [12:0] tx_sh;
        logic [3:0] tx_left;
        logic [3:0] tx_cnt;
        logic txd;
        ufb_rx_e rx_st;
        logic [12:0] rx_bits;
        logic [3:0] rx_idx;
        logic [3:0] rx_cnt;
        logic [8:0] rx_data;
        logic rx_full;
        logic pe;
        logic fe;
        logic ph;
        logic sclk;
        logic sclk_oe;
        logic [3:0] ists;
        logic [3:0] imask;
        logic irq;
        logic rd_sh;
        logic [7:0] rdata;
    } ufb_state_s;

    ufb_state_s s_ff;
    ufb_state_s nxt_s;

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    logic wr_data;
    logic wr_stat;
    logic wr_ctrl;
    logic wr_shared;
    logic wr_low;
    logic wr_ists;
    logic wr_imask;
    logic rd_hit;
    logic is_sync;
    logic par_en;
    logic par_odd;
    logic tick;
    logic drive_edge;
    logic sample_edge;
    logic tx_step;
    logic rx_smp;
    logic txc_ev;
    logic rxc_ev;
    logic pe_ev;
    logic fe_ev;
    logic pbit;
    logic [3:0] ovs_m1;
    logic [3:0] rx_pt;
    logic [3:0] n_bits;
    logic [3:0] fr_len;
    logic [3:0] rx_last;
    logic [8:0] dmask;
    logic [8:0] rdat;
    logic [12:0] frm;
    logic [12:0] rxf;
    logic [3:0] ev;

    // Whole block in one combinational pass
    always_comb begin
        nxt_s = s_ff;
        wr_data = i_wr && (i_addr == ADDR_DATA);
        wr_stat = i_wr && (i_addr == ADDR_STAT_A);
        wr_ctrl = i_wr && (i_addr == ADDR_CTRL_B);
        wr_shared = i_wr && (i_addr == ADDR_SHARED);
        wr_low = i_wr && (i_addr == ADDR_DIV_LOW);
        wr_ists = i_wr && (i_addr == ADDR_INT_STAT);
        wr_imask = i_wr && (i_addr == ADDR_INT_MASK);
        rd_hit = i_rd && (i_addr == ADDR_SHARED);
        is_sync = s_ff.frame[FRM_MODE];
        par_en = s_ff.frame[FRM_PAR_EN];
        par_odd = s_ff.frame[FRM_PAR_ODD];
        tick = 1'b0;
        tx_step = 1'b0;
        rx_smp = 1'b0;
        txc_ev = 1'b0;
        rxc_ev = 1'b0;
        pe_ev = 1'b0;
        fe_ev = 1'b0;
        pbit = 1'b0;
        rdat = '0;
        rxf = '0;

        // Character size from both halves of the code
        n_bits = ufb_char_len({s_ff.csz2, s_ff.frame[2:1]});
        dmask = 9'h1FF >> (4'h9 - n_bits);
        // Double speed halves the ticks per bit
        ovs_m1 = s_ff.dbl ? OVS_DOUBLE_M1 : OVS_NORMAL_M1;
        rx_pt = (s_ff.rx_idx == 4'h0) ? (ovs_m1 >> 1) : ovs_m1;
        fr_len = 4'h2 + n_bits + {3'h0, par_en} + {3'h0, s_ff.frame[FRM_STOP2]};
        rx_last = 4'h1 + n_bits + {3'h0, par_en};

        // ------------------------------------------------
        // Baud prescaler
        // ------------------------------------------------
        // Tick at clock over divisor plus one
        if (wr_low) begin
            nxt_s.div[7:0] = i_wdata;
            nxt_s.pre = {s_ff.div[11:8], i_wdata};
        end else if (s_ff.pre == 12'h000) begin
            tick = 1'b1;
            nxt_s.pre = s_ff.div;
        end else begin
            nxt_s.pre = s_ff.pre - 12'h001;
        end

        // Sync clock: one tick per half period
        if (tick) begin
            nxt_s.ph = ~s_ff.ph;
        end
        drive_edge = tick && !s_ff.ph;
        sample_edge = tick && s_ff.ph;
        // Polarity flips which edge drives data
        nxt_s.sclk = is_sync && (nxt_s.ph ^ s_ff.frame[FRM_POL]);
        nxt_s.sclk_oe = is_sync;

        // ------------------------------------------------
        // Transmitter
        // ------------------------------------------------
        // Async bit timer runs free so starts align to it
        if (tick) begin
            nxt_s.tx_cnt = (s_ff.tx_cnt == ovs_m1) ? 4'h0 : s_ff.tx_cnt + 4'h1;
        end
        tx_step = is_sync ? drive_edge : (tick && (s_ff.tx_cnt == ovs_m1));

        // Frame image, start bit first, stops as ones
        frm = '1;
        frm[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n_bits) begin
                frm[i + 1] = s_ff.thr[i];
            end
        end
        if (par_en) begin
            frm[4'h1 + n_bits] = ^(s_ff.thr & dmask) ^ par_odd;
        end

        if (tx_step) begin
            if (s_ff.tx_left != 4'h0) begin
                nxt_s.txd = s_ff.tx_sh[0];
                nxt_s.tx_sh = s_ff.tx_sh >> 1;
                nxt_s.tx_left = s_ff.tx_left - 4'h1;
            end else if (s_ff.thr_full && s_ff.txen) begin
                nxt_s.txd = frm[0];
                nxt_s.tx_sh = frm >> 1;
                nxt_s.tx_left = fr_len - 4'h1;
                nxt_s.tx_busy = 1'b1;
                nxt_s.thr_full = 1'b0;
            end else begin
                // Last stop bit has run its full time
                txc_ev = s_ff.tx_busy;
                nxt_s.tx_busy = 1'b0;
                nxt_s.txd = 1'b1;
            end
        end

        // Holding register; writes while full are dropped
        if (wr_data && !s_ff.thr_full) begin
            nxt_s.thr = {s_ff.txb8, i_wdata};
            nxt_s.thr_full = 1'b1;
        end

        // ------------------------------------------------
        // Receiver
        // ------------------------------------------------
        unique case (s_ff.rx_st)
            RX_IDLE: begin
                if (s_ff.rxen && !i_rxd && (is_sync ? sample_edge : tick)) begin
                    nxt_s.rx_st = RX_BUSY;
                    nxt_s.rx_cnt = 4'h0;
                    // Sync start bit is already sampled here
                    nxt_s.rx_idx = is_sync ? 4'h1 : 4'h0;
                    nxt_s.rx_bits = '0;
                end
            end
            RX_BUSY: begin
                if (is_sync) begin
                    rx_smp = sample_edge;
                end else if (tick) begin
                    if (s_ff.rx_cnt == rx_pt) begin
                        rx_smp = 1'b1;
                        nxt_s.rx_cnt = 4'h0;
                    end else begin
                        nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
                    end
                end
            end
        endcase

        // One stop bit checked whatever the stop setting
        if (rx_smp) begin
            rxf = s_ff.rx_bits;
            rxf[s_ff.rx_idx] = i_rxd;
            nxt_s.rx_bits = rxf;
            nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
            if (s_ff.rx_idx == 4'h0 && i_rxd) begin
                nxt_s.rx_st = RX_IDLE; // Glitch, not a start
            end else if (s_ff.rx_idx == rx_last) begin
                rdat = 9'(rxf >> 1) & dmask;
                pbit = rxf[4'h1 + n_bits];
                nxt_s.rx_st = RX_IDLE;
                nxt_s.rx_data = rdat;
                nxt_s.pe = par_en && ((^rdat ^ pbit) != par_odd);
                nxt_s.fe = !i_rxd;
                nxt_s.rx_full = 1'b1;
                rxc_ev = 1'b1;
                pe_ev = nxt_s.pe;
                fe_ev = !i_rxd;
            end
        end

        // Reading data empties the buffer; a frame landing now wins
        if (i_rd && (i_addr == ADDR_DATA) && !rxc_ev) begin
            nxt_s.rx_full = 1'b0;
        end
        // Disabling the receiver flushes it
        if (!s_ff.rxen) begin
            nxt_s.rx_st = RX_IDLE;
            nxt_s.rx_full = 1'b0;
            nxt_s.pe = 1'b0;
            nxt_s.fe = 1'b0;
        end

        // ------------------------------------------------
        // Register writes
        // ------------------------------------------------
        if (wr_stat) begin
            nxt_s.dbl = i_wdata[STA_DBL];
        end
        if (wr_ctrl) begin
            nxt_s.rxen = i_wdata[CTL_RXEN];
            nxt_s.txen = i_wdata[CTL_TXEN];
            nxt_s.csz2 = i_wdata[CTL_CSZ2];
            nxt_s.txb8 = i_wdata[CTL_TXB8];
        end
        // Select bit steers the shared location
        if (wr_shared) begin
            if (i_wdata[SEL_BIT]) begin
                nxt_s.frame = i_wdata[6:0];
            end else begin
                nxt_s.div[11:8] = i_wdata[3:0];
            end
        end
        if (wr_imask) begin
            nxt_s.imask = i_wdata[3:0];
        end

        // Sticky events; a set beats a same-cycle clear
        ev = '0;
        ev[EV_RXC] = rxc_ev;
        ev[EV_TXC] = txc_ev;
        ev[EV_PE] = pe_ev;
        ev[EV_FE] = fe_ev;
        nxt_s.ists = (s_ff.ists & ~(wr_ists ? i_wdata[3:0] : 4'h0)) | ev;
        nxt_s.irq = |(nxt_s.ists & nxt_s.imask);

        // ------------------------------------------------
        // Register reads
        // ------------------------------------------------
        // Back-to-back shared reads return the frame register
        nxt_s.rd_sh = rd_hit;
        nxt_s.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_DATA: nxt_s.rdata = s_ff.rx_data[7:0];
                ADDR_STAT_A: begin
                    nxt_s.rdata[STA_RX_FULL] = s_ff.rx_full;
                    nxt_s.rdata[STA_TX_EMPTY] = !s_ff.thr_full;
                    nxt_s.rdata[STA_FE] = s_ff.fe;
                    nxt_s.rdata[STA_PE] = s_ff.pe;
                    nxt_s.rdata[STA_DBL] = s_ff.dbl;
                end
                ADDR_CTRL_B: begin
                    nxt_s.rdata[CTL_RXEN] = s_ff.rxen;
                    nxt_s.rdata[CTL_TXEN] = s_ff.txen;
                    nxt_s.rdata[CTL_CSZ2] = s_ff.csz2;
                    nxt_s.rdata[CTL_RXB8] = s_ff.rx_data[8];
                    nxt_s.rdata[CTL_TXB8] = s_ff.txb8;
                end
                ADDR_SHARED: begin
                    if (s_ff.rd_sh) begin
                        nxt_s.rdata = {1'b1, s_ff.frame};
                    end else begin
                        nxt_s.rdata = {4'h0, s_ff.div[11:8]};
                    end
                end
                ADDR_DIV_LOW: nxt_s.rdata = s_ff.div[7:0];
                ADDR_INT_STAT: nxt_s.rdata = {4'h0, s_ff.ists};
                ADDR_INT_MASK: nxt_s.rdata = {4'h0, s_ff.imask};
                default: nxt_s.rdata = 8'h00; // Unmapped
            endcase
        end
    end

    // ------------------------------------------------
    // State register
    // ------------------------------------------------
    // Reset gives 8-bit async frames, line idle high
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            s_ff <= '0;
            s_ff.frame <= FRAME_RST;
            s_ff.txd <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state flops
    assign o_rdata = s_ff.rdata;
    assign o_txd = s_ff.txd;
    assign o_serial_clock_line = s_ff.sclk;
    assign o_serial_clock_line_oe = s_ff.sclk_oe;
    assign o_irq = s_ff.irq;

endmodule : ufb_usart

`default_nettype wire

// file: tb/ufb_props.sv
// Purpose: port checks for the serial port block
// Assumes: one clock domain, bound to the block
// Notes:   shadows the shared location from writes
`timescale 1ns/1ns
`default_nettype none
module ufb_props
    import ufb_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Serial lines and interrupt
    input wire logic i_rxd,
    input wire logic o_txd,
    input wire logic o_serial_clock_line,
    input wire logic o_serial_clock_line_oe,
    input wire logic o_irq
);
    // ----
    // Shadow state
    // ----
    logic [6:0] frm_ff;
    logic [3:0] dhi_ff;
    logic [11:0] low_ff;

    // Low run count: every async bit is a multiple of eight clocks
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            frm_ff <= FRAME_RST;
            dhi_ff <= 4'h0;
            low_ff <= 12'h000;
        end else begin
            if (i_wr && i_addr == ADDR_SHARED && i_wdata[SEL_BIT]) begin
                frm_ff <= i_wdata[6:0];
            end
            if (i_wr && i_addr == ADDR_SHARED && !i_wdata[SEL_BIT]) begin
                dhi_ff <= i_wdata[3:0];
            end
            low_ff <= o_txd ? 12'h000 : low_ff + 12'h001;
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_shared_rd;
        i_rd && i_addr == ADDR_SHARED;
    endsequence
    sequence s_lone_rd;
        !(i_rd && i_addr == ADDR_SHARED) ##1 s_shared_rd;
    endsequence

    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero");
    a_frame_read: assert property (s_shared_rd ##1 s_shared_rd |=> o_rdata == {1'b1, frm_ff})
        else $error("frame read wrong");
    a_divhi_read: assert property (s_lone_rd |=> o_rdata == {4'h0, dhi_ff})
        else $error("divisor high read wrong");
    a_unmapped_zero: assert property (i_rd && i_addr == 3'h7 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_mode_oe: assert property ($changed(frm_ff[FRM_MODE]) |-> ##[0:1] o_serial_clock_line_oe == frm_ff[FRM_MODE])
        else $error("clock enable ignores mode");
    a_async_clk: assert property (!o_serial_clock_line_oe |-> !o_serial_clock_line)
        else $error("clock active in async");
    a_sync_edge: assert property (o_serial_clock_line_oe && $changed(o_txd) |-> o_serial_clock_line != frm_ff[FRM_POL])
        else $error("data changed on wrong edge");
    a_irq_masked: assert property (i_wr && i_addr == ADDR_INT_MASK && i_wdata == 8'h00 |-> ##2 !o_irq)
        else $error("irq high with zero mask");
    a_async_bit: assert property (!frm_ff[FRM_MODE] && $rose(o_txd) |-> low_ff[2:0] == 3'h0)
        else $error("async bit length wrong");
endmodule : ufb_props

bind ufb_usart ufb_props ufb_props_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd),
    .o_serial_clock_line(o_serial_clock_line), .o_serial_clock_line_oe(o_serial_clock_line_oe), .o_irq(o_irq));
`default_nettype wire

// file: tb/ufb_remote.sv
// Purpose: remote async serial device on the data lines
// Assumes: bit length in clocks is given per call
// Notes:   sends one stop bit; line idles high
`timescale 1ns/1ns
`default_nettype none
module ufb_remote (
    // Clock and serial lines
    input wire logic i_clk,
    input wire logic i_txd,
    input wire logic i_sclk,
    output var logic o_rxd
);
    // Idle mark level until a frame is sent
    initial o_rxd = 1'b1;

    // Mid-bit sampling of one frame; ok drops on any framing slip
    task automatic recv(input int len, n, input logic [1:0] pm, input logic sb,
                        output logic [8:0] d, output logic ok);
        int t;
        d = 9'h000;
        t = 0;
        while (i_txd !== 1'b0 && t < 4000) begin
            @(posedge i_clk);
            t++;
        end
        repeat (len / 2) @(posedge i_clk);
        ok = (t < 4000) && (i_txd === 1'b0);
        for (int i = 0; i < n; i++) begin
            repeat (len) @(posedge i_clk);
            d[i] = i_txd;
        end
        if (pm[1]) begin
            repeat (len) @(posedge i_clk);
            ok &= (i_txd === (^d ^ pm[0]));
        end
        for (int i = 0; i <= int'(sb); i++) begin
            repeat (len) @(posedge i_clk);
            ok &= (i_txd === 1'b1);
        end
    endtask : recv

    // Drives one frame, parity flipped on request
    task automatic send(input int len, n, input logic [1:0] pm, input logic [8:0] d, input logic bad);
        @(posedge i_clk);
        o_rxd <= 1'b0;
        repeat (len) @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            o_rxd <= d[i];
            repeat (len) @(posedge i_clk);
        end
        if (pm[1]) begin
            o_rxd <= ^d ^ pm[0] ^ bad;
            repeat (len) @(posedge i_clk);
        end
        o_rxd <= 1'b1;
        repeat (len) @(posedge i_clk);
    endtask : send

    // Sync 8-bit frame; each bit changes once the clock reaches its drive level
    task automatic send_sync(input logic pol, input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            do @(posedge i_clk); while (i_sclk !== pol);
            do @(posedge i_clk); while (i_sclk === pol);
            o_rxd <= f[i];
        end
    endtask : send_sync
endmodule : ufb_remote
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: self-checking bench for the serial port block
// Assumes: remote model on the data lines
// Notes:   random data and formats from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import ufb_pkg::*;
;
    logic clk, rst, wr, rd, rxd, txd, sclk, soe, irq;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    int fails, samples_checked;

    ufb_usart ufb_usart_inst (.i_sys_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_rxd(rxd), .o_txd(txd), .o_serial_clock_line(sclk),
        .o_serial_clock_line_oe(soe), .o_irq(irq));
    ufb_remote ufb_remote_inst (.i_clk(clk), .i_txd(txd), .i_sclk(sclk), .o_rxd(rxd));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----
    // Tasks
    // ----
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    // Repeated strobe gives back-to-back reads of one address
    task automatic rreg(input logic [2:0] a, input int n, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        repeat (n) @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rreg

    task automatic chk(input logic [9:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    // Data bits for a size code; reserved codes behave as eight
    function automatic int bits_of(input logic [2:0] c);
        return (c == 3'h7) ? 9 : (c > 3'h3) ? 8 : int'(c) + 5;
    endfunction : bits_of

    // Hang guard, far beyond the expected run
    initial begin
        #360000;
        fails++;
        summarize();
    end

    // ----
    // Main sequence
    // ----
    initial begin
        logic [8:0] d, got;
        logic [7:0] s;
        logic [2:0] c;
        logic [1:0] pm;
        logic ok, sb, dbl, bad;
        int n, len, dv, t;
        {wr, rd, addr, wdata} = '0;
        rst = 1'b1;
        fails = 0;
        samples_checked = 0;
        void'($urandom(33572));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rreg(ADDR_SHARED, 1, s);
        chk(10'(s), 10'h000);
        rreg(ADDR_SHARED, 2, s);
        chk(10'(s), 10'({1'b1, FRAME_RST}));
        rreg(3'h7, 1, s);
        chk(10'(s), 10'h000);
        wreg(ADDR_INT_MASK, 8'h02);
        // Every size and parity code, both directions per format
        for (int k = 0; k < 10; k++) begin
            c = 3'(k);
            pm = 2'(k);
            sb = 1'($urandom % 2);
            dbl = 1'($urandom % 2);
            dv = (k == 0) ? 0 : int'($urandom % 3);
            n = bits_of(c);
            len = (dv + 1) * (dbl ? 8 : 16);
            d = 9'($urandom) & 9'((1 << n) - 1);
            wreg(ADDR_SHARED, {1'b1, 1'b0, pm, sb, c[1:0], 1'b0});
            wreg(ADDR_SHARED, 8'h00);
            wreg(ADDR_STAT_A, {6'h00, dbl, 1'b0});
            wreg(ADDR_CTRL_B, {3'h0, 2'h3, c[2], 1'b0, d[8]});
            wreg(ADDR_DIV_LOW, 8'(dv));
            wreg(ADDR_INT_STAT, 8'h0F);
            wreg(ADDR_DATA, d[7:0]);
            ufb_remote_inst.recv(len, n, pm, sb, got, ok);
            @(negedge clk);
            chk(10'(irq), 10'h000);
            t = 0;
            while (irq !== 1'b1 && t < len) begin
                @(negedge clk);
                t++;
            end
            chk(10'(irq === 1'b1 && t <= len / 2 + 4), 10'h001);
            chk({ok, got}, {1'b1, d});
            bad = 1'($urandom % 2);
            ufb_remote_inst.send(len, n, pm, d, bad);
            repeat (len) @(posedge clk);
            rreg(ADDR_STAT_A, 1, s);
            chk(10'({s[STA_RX_FULL], s[STA_FE], s[STA_PE]}), 10'({2'b10, pm[1] & bad}));
            rreg(ADDR_CTRL_B, 1, s);
            if (n == 9) chk(10'(s[CTL_RXB8]), 10'(d[8]));
            rreg(ADDR_DATA, 1, s);
            chk(10'(s), 10'(d[7:0]));
        end
        // Synchronous send with each clock polarity
        for (int p = 0; p < 2; p++) begin
            wreg(ADDR_STAT_A, 8'h00);
            wreg(ADDR_SHARED, 8'hC6 | 8'(p));
            wreg(ADDR_CTRL_B, 8'h18);
            wreg(ADDR_DIV_LOW, 8'h01);
            wreg(ADDR_INT_STAT, 8'h0F);
            wreg(ADDR_DATA, 8'($urandom));
            t = 0;
            while (irq !== 1'b1 && t < 200) begin
                @(negedge clk);
                t++;
            end
            chk(10'({soe, irq}), 10'h003);
            // Sync receive: sampled on the edge opposite the drive edge
            d = 9'($urandom);
            ufb_remote_inst.send_sync(1'(p), d[7:0]);
            repeat (4) @(posedge clk);
            rreg(ADDR_DATA, 1, s);
            chk(10'(s), 10'(d[7:0]));
        end
        // Mask, reunmask, then clear by writing one
        wreg(ADDR_SHARED, 8'h86);
        wreg(ADDR_INT_MASK, 8'h00);
        repeat (2) @(negedge clk);
        chk(10'(irq), 10'h000);
        rreg(ADDR_INT_STAT, 1, s);
        chk(10'(s[EV_TXC]), 10'h001);
        wreg(ADDR_INT_MASK, 8'h02);
        repeat (2) @(negedge clk);
        chk(10'(irq), 10'h001);
        wreg(ADDR_INT_STAT, 8'h02);
        repeat (2) @(negedge clk);
        chk(10'(irq), 10'h000);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
